// File: rtl/crc_cmd_ctrl.v
// Command register, watchdog timer and interrupt logic of a network controller.
// Functional notes
// - Command bits 9, 8, 1 and 0 are cleared by the block when their command finishes; timer run clears when the watchdog expires.
// - Writing zero to a command bit other than software reset changes nothing.
// - The loaded 32-bit watchdog value decrements only after the timer run bit is set.
// - The watchdog reaching zero raises an interrupt when the timer source is enabled.
// - Hardware reset sets command bits 7, 4 and 2 and clears all others.
// - Software reset clears bits 9, 8, 1, 0, sets 7 and 2, and leaves the rest.
// - The filter load command starts a filter memory load from the filter descriptor pointer.
// - The resource fetch command reads the descriptor at the resource read pointer.
// - While software reset is set, engines are held reset, CRC is off, tallies are paused.
// - The block is not operational until software reset is cleared; hardware reset sets it.
// - Setting timer run starts or resumes counting and clears halt; run clears on halt.
// - Setting timer halt stops the timer and clears run; halt comes up set.
// - Run and halt written together act as halt.
`timescale 1ns/1ps
`include "crc_defs.vh"
module crc_cmd_ctrl #(
   parameter TMR_W = 32
) (
   // Clock, reset, enable
   input  wire             clk_sys,
   input  wire             rst,
   input  wire             ce,
   // Wishbone slave
   input  wire             wb_cyc_i,
   input  wire             wb_stb_i,
   input  wire             wb_we_i,
   input  wire [5:0]       wb_adr_i,
   input  wire [3:0]       wb_sel_i,
   input  wire [31:0]      wb_dat_i,
   output reg  [31:0]      wb_dat_o,
   output reg              wb_ack_o,
   // Command engines
   output reg              af_load_start_ff,
   output reg  [15:0]      af_desc_ptr_ff,
   output reg              fetch_start_ff,
   output reg  [15:0]      rrp_ptr_ff,
   output reg              engines_reset_ff,
   output reg              crc_disable_ff,
   output reg              tally_pause_ff,
   output reg  [15:0]      cmd_bits_ff,
   // Interrupt
   output reg              irq_ff
);
   // ************************************************************
   // Declarations
   // ************************************************************
   reg  [15:0]      cmd_ff;
   reg  [15:0]      nxt_cmd;
   reg  [TMR_W-1:0] tmr_ff;
   reg  [TMR_W-1:0] nxt_tmr;
   reg  [`CRC_IRQ_W-1:0] stat_ff;
   reg  [`CRC_IRQ_W-1:0] nxt_stat;
   reg  [`CRC_IRQ_W-1:0] mask_ff;
   reg              af_busy_ff;
   reg              fetch_busy_ff;
   reg              tmr_done;
   reg  [31:0]      rd_mux;
   wire             acc;
   wire             wr;
   wire [15:0]      rrp_q;
   wire [15:0]      impl_mask;

   assign acc       = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr        = acc && wb_we_i;
   assign impl_mask = `CRC_CMD_IMPL;

   // Byte-lane merge of a 16-bit write over the old value.
   function [15:0] apply_sel;
      input [15:0] old;
      input [15:0] nw;
      input [1:0]  sel;
      begin
         apply_sel = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   function is_wr;
      input [5:0] adr;
      begin
         is_wr = wr && (wb_adr_i == adr);
      end
   endfunction

   // ************************************************************
   // Resource read pointer storage
   // ************************************************************
   crc_reg16 #(
      .W (16)
   ) u_rrp (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .we      (is_wr(`CRC_ADR_RRP)),
      .wdata   (apply_sel(rrp_q, wb_dat_i[15:0], wb_sel_i[1:0])),
      .q_ff    (rrp_q)
   );

   // ************************************************************
   // Command register next state
   // ************************************************************
   always @* begin
      nxt_cmd  = cmd_ff;
      tmr_done = 1'b0;
      // Completion from the engines clears the command bits.
      if (is_wr(`CRC_ADR_ENG_DONE)) begin
         if (wb_dat_i[0])
            nxt_cmd[`CRC_B_AF_LOAD] = 1'b0;
         if (wb_dat_i[1])
            nxt_cmd[`CRC_B_FETCH] = 1'b0;
         if (wb_dat_i[2])
            nxt_cmd[`CRC_B_TX] = 1'b0;
         if (wb_dat_i[3])
            nxt_cmd[`CRC_B_HALT_TX] = 1'b0;
      end
      if (!cmd_ff[`CRC_B_SW_RST] && cmd_ff[`CRC_B_TMR_RUN] && tmr_ff == {TMR_W{1'b0}}) begin
         tmr_done = 1'b1;
         nxt_cmd[`CRC_B_TMR_RUN]  = 1'b0;
         nxt_cmd[`CRC_B_TMR_HALT] = 1'b1;
      end
      if (is_wr(`CRC_ADR_CMD) && wb_sel_i[0]) begin
         // The reset bit alone is written both ways.
         nxt_cmd[`CRC_B_SW_RST] = wb_dat_i[`CRC_B_SW_RST];
         if (wb_dat_i[`CRC_B_SW_RST] && !cmd_ff[`CRC_B_SW_RST]) begin
            nxt_cmd = (cmd_ff & ~`CRC_CMD_SW_CLR) | `CRC_CMD_SW_SET;
         end else if (!cmd_ff[`CRC_B_SW_RST]) begin
            // Commands are ignored while reset is held.
            // Only ones take effect; zeros leave bits alone.
            nxt_cmd[6:0] = nxt_cmd[6:0] | (wb_dat_i[6:0] & impl_mask[6:0]);
            if (wb_sel_i[1])
               nxt_cmd[9:8] = nxt_cmd[9:8] | wb_dat_i[9:8];
            if (wb_dat_i[`CRC_B_TMR_HALT]) begin
               nxt_cmd[`CRC_B_TMR_RUN] = 1'b0;
            end else if (wb_dat_i[`CRC_B_TMR_RUN]) begin
               nxt_cmd[`CRC_B_TMR_HALT] = 1'b0;
            end
            if (wb_dat_i[`CRC_B_RX_EN])
               nxt_cmd[`CRC_B_RX_DIS] = 1'b0;
            if (wb_dat_i[`CRC_B_RX_DIS])
               nxt_cmd[`CRC_B_RX_EN] = 1'b0;
         end
      end
      nxt_cmd = nxt_cmd & `CRC_CMD_IMPL;
   end

   // ************************************************************
   // Watchdog timer next state
   // ************************************************************
   always @* begin
      nxt_tmr = tmr_ff;
      if (is_wr(`CRC_ADR_TMR_LO))
         nxt_tmr[15:0] = apply_sel(tmr_ff[15:0], wb_dat_i[15:0], wb_sel_i[1:0]);
      else if (is_wr(`CRC_ADR_TMR_HI))
         nxt_tmr[TMR_W-1:16] = apply_sel(tmr_ff[TMR_W-1:16], wb_dat_i[15:0], wb_sel_i[1:0]);
      else if (!cmd_ff[`CRC_B_SW_RST] && cmd_ff[`CRC_B_TMR_RUN] && tmr_ff != {TMR_W{1'b0}})
         nxt_tmr = tmr_ff - {{(TMR_W-1){1'b0}}, 1'b1};
   end

   // ************************************************************
   // Interrupt status: set wins over clear
   // ************************************************************
   always @* begin
      nxt_stat = stat_ff;
      if (is_wr(`CRC_ADR_IRQ_CLR))
         nxt_stat = nxt_stat & ~wb_dat_i[`CRC_IRQ_W-1:0];
      if (tmr_done)
         nxt_stat[`CRC_IRQ_TMR] = 1'b1;
      if (af_load_start_ff)
         nxt_stat[`CRC_IRQ_AF] = 1'b1;
      if (fetch_start_ff)
         nxt_stat[`CRC_IRQ_FETCH] = 1'b1;
   end

   // ************************************************************
   // Read mux
   // ************************************************************
   always @* begin
      case (wb_adr_i)
         `CRC_ADR_CMD:      rd_mux = {16'h0000, cmd_ff};
         `CRC_ADR_TMR_LO:   rd_mux = {16'h0000, tmr_ff[15:0]};
         `CRC_ADR_TMR_HI:   rd_mux = {16'h0000, tmr_ff[TMR_W-1:16]};
         `CRC_ADR_AF_PTR:   rd_mux = {16'h0000, af_desc_ptr_ff};
         `CRC_ADR_RRP:      rd_mux = {16'h0000, rrp_q};
         `CRC_ADR_IRQ_STAT: rd_mux = {29'h00000000, stat_ff};
         `CRC_ADR_IRQ_MASK: rd_mux = {29'h00000000, mask_ff};
         `CRC_ADR_TMR_CNT:  rd_mux = tmr_ff;
         default:           rd_mux = 32'h00000000;
      endcase
   end

   // ************************************************************
   // State registers
   // ************************************************************
   always @(posedge clk_sys) begin
      if (rst) begin
         cmd_ff           <= `CRC_CMD_HW_RST;
         tmr_ff           <= {TMR_W{1'b0}};
         stat_ff          <= {`CRC_IRQ_W{1'b0}};
         mask_ff          <= {`CRC_IRQ_W{1'b0}};
         af_desc_ptr_ff   <= 16'h0000;
         af_busy_ff       <= 1'b0;
         fetch_busy_ff    <= 1'b0;
         af_load_start_ff <= 1'b0;
         fetch_start_ff   <= 1'b0;
         rrp_ptr_ff       <= 16'h0000;
         engines_reset_ff <= 1'b1;
         crc_disable_ff   <= 1'b1;
         tally_pause_ff   <= 1'b1;
         cmd_bits_ff      <= `CRC_CMD_HW_RST;
         irq_ff           <= 1'b0;
         wb_ack_o         <= 1'b0;
         wb_dat_o         <= 32'h00000000;
      end else if (ce) begin
         cmd_ff   <= nxt_cmd;
         tmr_ff   <= nxt_tmr;
         stat_ff  <= nxt_stat;
         wb_ack_o <= acc;
         wb_dat_o <= (acc && !wb_we_i) ? rd_mux : 32'h00000000;
         if (is_wr(`CRC_ADR_IRQ_MASK))
            mask_ff <= wb_dat_i[`CRC_IRQ_W-1:0];
         if (is_wr(`CRC_ADR_AF_PTR))
            af_desc_ptr_ff <= apply_sel(af_desc_ptr_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
         // One start pulse per rising command bit; engines report done.
         af_busy_ff       <= nxt_cmd[`CRC_B_AF_LOAD];
         fetch_busy_ff    <= nxt_cmd[`CRC_B_FETCH];
         af_load_start_ff <= nxt_cmd[`CRC_B_AF_LOAD] && !af_busy_ff;
         fetch_start_ff   <= nxt_cmd[`CRC_B_FETCH] && !fetch_busy_ff;
         if (nxt_cmd[`CRC_B_FETCH] && !fetch_busy_ff)
            rrp_ptr_ff <= rrp_q;
         engines_reset_ff <= nxt_cmd[`CRC_B_SW_RST];
         crc_disable_ff   <= nxt_cmd[`CRC_B_SW_RST];
         tally_pause_ff   <= nxt_cmd[`CRC_B_SW_RST];
         cmd_bits_ff      <= nxt_cmd;
         irq_ff           <= |(nxt_stat & (is_wr(`CRC_ADR_IRQ_MASK) ?
                             wb_dat_i[`CRC_IRQ_W-1:0] : mask_ff));
      end
   end
endmodule

// File: rtl/crc_defs.vh
// Constants for the command register block: offsets, bit positions, reset values.
`ifndef CRC_DEFS_VH
`define CRC_DEFS_VH
// ************************************************************
// Register byte addresses (Wishbone, one word each)
// ************************************************************
`define CRC_ADR_CMD       6'h00
`define CRC_ADR_TMR_LO    6'h04
`define CRC_ADR_TMR_HI    6'h08
`define CRC_ADR_AF_PTR    6'h0C
`define CRC_ADR_RRP       6'h10
`define CRC_ADR_IRQ_STAT  6'h14
`define CRC_ADR_IRQ_CLR   6'h18
`define CRC_ADR_IRQ_MASK  6'h1C
`define CRC_ADR_ENG_DONE  6'h20
`define CRC_ADR_TMR_CNT   6'h24
// ************************************************************
// Command register bit positions
// ************************************************************
`define CRC_B_HALT_TX     0
`define CRC_B_TX          1
`define CRC_B_RX_DIS      2
`define CRC_B_RX_EN       3
`define CRC_B_TMR_HALT    4
`define CRC_B_TMR_RUN     5
`define CRC_B_SW_RST      7
`define CRC_B_FETCH       8
`define CRC_B_AF_LOAD     9
// ************************************************************
// Reset values and masks
// ************************************************************
`define CRC_CMD_HW_RST    16'h0094
`define CRC_CMD_SW_CLR    16'h0303
`define CRC_CMD_SW_SET    16'h0084
`define CRC_CMD_IMPL      16'h03BF
`define CRC_IRQ_W         3
`define CRC_IRQ_TMR       0
`define CRC_IRQ_AF        1
`define CRC_IRQ_FETCH     2
`endif

// File: rtl/crc_reg16.v
// Small 16-bit register with write enable whose output comes from a flip-flop.
`timescale 1ns/1ps
module crc_reg16 #(
   parameter W = 16
) (
   // Clocking
   input  wire         clk_sys,
   input  wire         rst,
   input  wire         ce,
   // Write port
   input  wire         we,
   input  wire [W-1:0] wdata,
   // Read port
   output reg  [W-1:0] q_ff
);
   always @(posedge clk_sys) begin
      if (rst) begin
         q_ff <= {W{1'b0}};
      end else if (ce && we) begin
         q_ff <= wdata;
      end
   end
endmodule

// File: tb/crc_cmd_ctrl_chk.sv
// Concurrent checks on the ports of the command register block.
`timescale 1ns/1ps
module crc_cmd_ctrl_chk #(
   parameter TMR_W = 32
) (
   // Clock and reset
   input wire        clk_sys,
   input wire        rst,
   input wire        ce,
   // Bus handshake
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_ack_o,
   // Engine controls
   input wire        af_load_start_ff,
   input wire        fetch_start_ff,
   input wire        engines_reset_ff,
   input wire        crc_disable_ff,
   input wire        tally_pause_ff,
   input wire [15:0] cmd_bits_ff,
   input wire        irq_ff
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ************************************************************
   // Assertions
   // ************************************************************
   AST_ACK_REQ: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
      else $error("request not acknowledged");
   AST_HW_RST: assert property ($past(rst) |-> cmd_bits_ff == 16'h0094)
      else $error("command value wrong after reset");
   AST_RSVD: assert property ((cmd_bits_ff & 16'hFC40) == 16'h0000)
      else $error("reserved command bit set");
   AST_ENG_RST: assert property ($rose(cmd_bits_ff[7]) |-> ##[0:1]
      (engines_reset_ff && crc_disable_ff && tally_pause_ff)) else $error("engines not held");
   AST_RUN_HALT: assert property (!(cmd_bits_ff[5] && cmd_bits_ff[4]))
      else $error("run and halt both set");
   AST_AF: assert property (af_load_start_ff |-> cmd_bits_ff[9] ##1 !af_load_start_ff)
      else $error("filter load pulse wrong");
   AST_FETCH: assert property (fetch_start_ff |-> cmd_bits_ff[8] ##1 !fetch_start_ff)
      else $error("fetch pulse wrong");
   AST_SW_HOLD: assert property (cmd_bits_ff[7] && $past(cmd_bits_ff[7]) |->
      cmd_bits_ff[9:8] == 2'b00) else $error("command taken during software reset");
   cover property ($rose(irq_ff));
   cover property (af_load_start_ff);
   cover property ($fell(cmd_bits_ff[7]));
endmodule

bind crc_cmd_ctrl crc_cmd_ctrl_chk #(.TMR_W(TMR_W)) u_chk (.clk_sys(clk_sys), .rst(rst),
   .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .af_load_start_ff(af_load_start_ff), .fetch_start_ff(fetch_start_ff),
   .engines_reset_ff(engines_reset_ff), .crc_disable_ff(crc_disable_ff),
   .tally_pause_ff(tally_pause_ff), .cmd_bits_ff(cmd_bits_ff), .irq_ff(irq_ff));

// File: tb/crc_cmd_ctrl_tb.sv
// Self-checking testbench for the command register block.
`timescale 1ns/1ps
`include "crc_defs.vh"
module crc_cmd_ctrl_tb;
   reg         clk_sys, rst, ce, cyc, stb, we;
   reg  [5:0]  adr;
   reg  [31:0] dat, rd;
   wire [31:0] dat_o;
   wire        ack, af_go, fe_go, eng_rst, crc_dis, tal_p, irq;
   wire [15:0] af_ptr, resource_read_pointer, cmd;
   integer     mismatches, check_count, af_n, fe_n, n;

   crc_cmd_ctrl #(.TMR_W(32)) dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .af_load_start_ff(af_go), .af_desc_ptr_ff(af_ptr),
      .fetch_start_ff(fe_go), .rrp_ptr_ff(resource_read_pointer), .engines_reset_ff(eng_rst),
      .crc_disable_ff(crc_dis), .tally_pause_ff(tal_p), .cmd_bits_ff(cmd), .irq_ff(irq));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Start pulses last one cycle, so they are counted rather than polled.
   always @(posedge clk_sys) begin
      if (af_go === 1'b1) af_n = af_n + 1;
      if (fe_go === 1'b1) fe_n = fe_n + 1;
   end

   task finish_test;
      begin
         if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task bus(input [5:0] a, input w, input [31:0] d);
      integer k;
      begin
         @(posedge clk_sys);
         cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
         k = 0;
         @(posedge clk_sys);
         while (ack !== 1'b1 && k < 50) begin
            @(posedge clk_sys);
            k = k + 1;
         end
         chk({31'h0, ack}, 32'h1);
         rd = dat_o;
         cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      end
   endtask
   task wr(input [5:0] a, input [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task rdc(input [5:0] a, input [31:0] exp);
      begin
         bus(a, 1'b0, 32'h0);
         chk(rd, exp);
      end
   endtask

   initial begin
      rst = 1'b1; ce = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 6'h00; dat = 32'h0;
      mismatches = 0; check_count = 0; af_n = 0; fe_n = 0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(`CRC_ADR_CMD, 32'h94);
      chk({29'h0, eng_rst, crc_dis, tal_p}, 32'h7);
      // Bit 7 written as zero lifts the reset; the load request in the same write is dropped.
      wr(`CRC_ADR_CMD, 32'h200);
      rdc(`CRC_ADR_CMD, 32'h14);
      wr(`CRC_ADR_CMD, 32'h0);
      rdc(`CRC_ADR_CMD, 32'h14);
      chk({31'h0, eng_rst}, 32'h0);
      wr(`CRC_ADR_TMR_LO, 32'h14);
      wr(`CRC_ADR_TMR_HI, 32'h0);
      wr(`CRC_ADR_IRQ_MASK, 32'h1);
      repeat (4) @(posedge clk_sys);
      rdc(`CRC_ADR_TMR_CNT, 32'h14);
      wr(`CRC_ADR_CMD, 32'h20);
      rdc(`CRC_ADR_CMD, 32'h24);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n = n + 1;
      end
      chk({31'h0, irq}, 32'h1);
      rdc(`CRC_ADR_CMD, 32'h14);
      rdc(`CRC_ADR_IRQ_STAT, 32'h1);
      wr(`CRC_ADR_IRQ_CLR, 32'h1);
      rdc(`CRC_ADR_IRQ_STAT, 32'h0);
      wr(`CRC_ADR_TMR_LO, 32'h9);
      wr(`CRC_ADR_CMD, 32'h30);
      rdc(`CRC_ADR_CMD, 32'h14);
      rdc(`CRC_ADR_TMR_CNT, 32'h9);
      wr(`CRC_ADR_CMD, 32'hFC40);
      rdc(`CRC_ADR_CMD, 32'h14);
      wr(`CRC_ADR_AF_PTR, 32'h1234);
      // No transmit command is pending here, so the filter load is legal.
      wr(`CRC_ADR_CMD, 32'h200);
      rdc(`CRC_ADR_CMD, 32'h214);
      chk(af_n, 1);
      chk({16'h0, af_ptr}, 32'h1234);
      wr(`CRC_ADR_ENG_DONE, 32'h1);
      rdc(`CRC_ADR_CMD, 32'h14);
      wr(`CRC_ADR_RRP, 32'h55AA);
      // Still in the set-up phase, before any receive traffic.
      wr(`CRC_ADR_CMD, 32'h100);
      rdc(`CRC_ADR_CMD, 32'h114);
      chk(fe_n, 1);
      chk({16'h0, resource_read_pointer}, 32'h55AA);
      chk({31'h0, irq}, 32'h0);
      wr(`CRC_ADR_ENG_DONE, 32'h2);
      rdc(`CRC_ADR_CMD, 32'h14);
      wr(`CRC_ADR_TMR_HI, 32'h1);
      wr(`CRC_ADR_CMD, 32'h123);
      rdc(`CRC_ADR_CMD, 32'h127);
      wr(`CRC_ADR_CMD, 32'h80);
      rdc(`CRC_ADR_CMD, 32'hA4);
      chk({29'h0, eng_rst, crc_dis, tal_p}, 32'h7);
      wr(`CRC_ADR_CMD, 32'h0);
      rdc(`CRC_ADR_CMD, 32'h24);
      rdc(6'h3C, 32'h0);
      finish_test;
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      mismatches = mismatches + 1;
      finish_test;
   end
endmodule
